// ### rtl/idp_page_builder.sv
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module idp_page_builder #(
  parameter logic [15:0] GEO_CYLINDERS = 16'h0000,
  parameter logic [15:0] GEO_HEADS     = 16'h0000,
  parameter logic [15:0] GEO_SPT       = 16'h0000
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  output logic             cmd_accept,
  output logic             cmd_reject,
  output logic [15:0]      page_data,
  output logic             page_valid,
  output logic             page_last,
  input  wire logic        page_ready
);
  import idp_pkg::*;

  // Word 3 carries the head count in its low byte only
  if (GEO_HEADS[15:8] != 8'h00) begin : g_heads_chk
    $error("GEO_HEADS must fit in eight bits");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] capacity_r;
  logic [31:0] serial_r;
  logic [15:0] security_r;
  logic [7:0]  wp_status_r;
  logic [15:0] maxcur_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [15:0] pages_sent_r;

  idp_state_e  state_r;
  logic [7:0]  idx_r;
  logic [7:0]  sum_r;
  logic [15:0] data_r;
  logic        valid_r;
  logic        last_r;
  logic        accept_r;
  logic        reject_r;

  logic        ncq_en;
  logic        mdma_en;
  logic [2:0]  mdma_sel;
  logic [7:0]  udma_sel;
  logic        busy;
  logic        acc_done;
  logic        addr_ok;
  logic        load;
  logic [15:0] word_nxt;
  logic [7:0]  sum_nxt;
  logic [31:0] rd_nxt;

  assign ncq_en   = ctrl_r[CTRL_NCQ_BIT];
  assign mdma_en  = ctrl_r[CTRL_MDMA_BIT];
  assign mdma_sel = ctrl_r[CTRL_MSEL_LSB +: 3];
  assign udma_sel = ctrl_r[CTRL_USEL_LSB +: 8];
  assign busy     = (state_r != IDP_IDLE);
  assign acc_done = psel & penable & pready_r;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb begin
    addr_ok = 1'b1;
    rd_nxt  = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL:     rd_nxt = ctrl_r;
      ADDR_CAPACITY: rd_nxt = capacity_r;
      ADDR_SERIAL:   rd_nxt = serial_r;
      ADDR_SECURITY: rd_nxt = {wp_status_r, 8'h00, security_r};
      ADDR_STATUS:   rd_nxt = {pages_sent_r, idx_r, 7'h00, busy};
      ADDR_MAXCUR:   rd_nxt = {16'h0000, maxcur_r};
      default:       addr_ok = 1'b0;
    endcase
  end

  // One wait cycle: pready rises in the second access cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (psel & penable & ~pready_r) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~addr_ok;
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
  end

  // Register writes are dropped, not held, while a page is in flight so that
  // the checksum always matches the words actually sent
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r      <= CTRL_RESET;
      capacity_r  <= CAPACITY_RESET;
      serial_r    <= SERIAL_RESET;
      security_r  <= SECURITY_RESET;
      wp_status_r <= 8'h00;
      maxcur_r    <= MAXCUR_RESET;
    end else if (acc_done & pwrite & ~busy) begin
      unique case (paddr)
        ADDR_CTRL:     ctrl_r      <= pwdata;
        ADDR_CAPACITY: capacity_r  <= pwdata;
        ADDR_SERIAL:   serial_r    <= pwdata;
        ADDR_SECURITY: begin
          security_r  <= pwdata[15:0];
          wp_status_r <= pwdata[SEC_WP_LSB +: 8];
        end
        ADDR_MAXCUR:   maxcur_r    <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Page content
  // ----------------------------------------------------------------
  always_comb begin
    word_nxt = 16'h0000;
    unique case (idx_r)
      8'd0:   word_nxt = GEN_CONFIG;
      8'd1:   word_nxt = GEO_CYLINDERS;
      8'd3:   word_nxt = GEO_HEADS;
      8'd5:   word_nxt = WORD5_VAL;
      8'd6:   word_nxt = GEO_SPT;
      8'd7:   word_nxt = capacity_r[31:16];
      8'd8:   word_nxt = capacity_r[15:0];
      8'd10, 8'd11, 8'd12, 8'd13, 8'd14,
      8'd15, 8'd16, 8'd17: word_nxt = SPACE_PAIR;
      8'd18:  word_nxt = serial_r[31:16];
      8'd19:  word_nxt = serial_r[15:0];
      8'd60:  word_nxt = capacity_r[15:0];
      8'd61:  word_nxt = capacity_r[31:16];
      8'd63:  word_nxt = mdma_en ? {5'h00, mdma_sel, MDMA_SUPPORT} : 16'h0000;
      8'd64:  word_nxt = PIO_ADV;
      8'd65, 8'd66, 8'd67, 8'd68: word_nxt = CYCLE_TIME;
      8'd69:  word_nxt = CARD_SPEC;
      8'd75:  word_nxt = ncq_en ? QUEUE_DEPTH : 16'h0000;
      8'd76:  word_nxt = ncq_en ? LINK_CAP_NCQ : LINK_CAP_PLAIN;
      8'd80:  word_nxt = MAJOR_VER;
      8'd81:  word_nxt = ALL_ONES;
      8'd82:  word_nxt = FSET_SUP0;
      8'd83:  word_nxt = FSET_SUP1;
      8'd84:  word_nxt = FSET_COMMON;
      8'd85:  word_nxt = FSET_ENA0;
      8'd86:  word_nxt = FSET_ENA1;
      8'd87:  word_nxt = FSET_COMMON;
      8'd88:  word_nxt = {udma_sel, UDMA_SUPPORT};
      8'd92:  word_nxt = MASTER_PW_REV;
      8'd100: word_nxt = capacity_r[15:0];
      8'd101: word_nxt = capacity_r[31:16];
      8'd105: word_nxt = ONE_WORD;
      8'd119, 8'd120: word_nxt = FSET_EXT;
      8'd128: word_nxt = security_r;
      8'd129: word_nxt = {wp_status_r, 8'h00};
      8'd160: word_nxt = maxcur_r;
      8'd161: word_nxt = PHY_SLEEP_CAP;
      8'd169: word_nxt = ONE_WORD;
      8'd217: word_nxt = ONE_WORD;
      8'd222: word_nxt = XPORT_MAJOR;
      8'd223: word_nxt = ALL_ONES;
      LAST_WORD: word_nxt = {8'(8'h00 - sum_r - INTEGRITY_SIG), INTEGRITY_SIG};
      default: ;
    endcase
  end

  assign sum_nxt = 8'(sum_r + word_nxt[15:8] + word_nxt[7:0]);

  // ----------------------------------------------------------------
  // Command intake and page stream
  // ----------------------------------------------------------------
  // In IDP_SEND the output slot refills whenever it is empty or being taken
  assign load = (state_r == IDP_SEND) & (~valid_r | page_ready);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accept_r <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      accept_r <= cmd_valid & ~busy & (cmd_code == CMD_IDENTIFY);
      reject_r <= cmd_valid & (busy | (cmd_code != CMD_IDENTIFY));
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= IDP_IDLE;
    end else begin
      unique case (state_r)
        IDP_IDLE: begin
          if (cmd_valid & (cmd_code == CMD_IDENTIFY)) begin
            state_r <= IDP_SEND;
          end
        end
        IDP_SEND: begin
          if (load & (idx_r == LAST_WORD)) begin
            state_r <= IDP_DRAIN;
          end
        end
        IDP_DRAIN: begin
          if (page_ready) begin
            state_r <= IDP_IDLE;
          end
        end
        default: state_r <= IDP_IDLE;
      endcase
    end
  end

  // Word index and running byte sum over the page
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_r <= 8'h00;
      sum_r <= 8'h00;
    end else if (state_r == IDP_IDLE) begin
      idx_r <= 8'h00;
      sum_r <= 8'h00;
    end else if (load) begin
      idx_r <= 8'(idx_r + 8'h01);
      sum_r <= sum_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_r  <= 16'h0000;
      valid_r <= 1'b0;
      last_r  <= 1'b0;
    end else if (load) begin
      data_r  <= word_nxt;
      valid_r <= 1'b1;
      last_r  <= (idx_r == LAST_WORD);
    end else if (page_ready) begin
      data_r  <= 16'h0000;
      valid_r <= 1'b0;
      last_r  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pages_sent_r <= 16'h0000;
    end else if (valid_r & last_r & page_ready) begin
      pages_sent_r <= 16'(pages_sent_r + 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign cmd_accept = accept_r;
  assign cmd_reject = reject_r;
  assign page_data  = data_r;
  assign page_valid = valid_r;
  assign page_last  = last_r;

endmodule

// ### inc/idp_pkg.sv
package idp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_CAPACITY  = 8'h04;
  localparam logic [7:0]  ADDR_SERIAL    = 8'h08;
  localparam logic [7:0]  ADDR_SECURITY  = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;
  localparam logic [7:0]  ADDR_MAXCUR    = 8'h14;

  localparam int          CTRL_NCQ_BIT   = 0;
  localparam int          CTRL_MDMA_BIT  = 1;
  localparam int          CTRL_MSEL_LSB  = 8;
  localparam int          CTRL_USEL_LSB  = 16;
  localparam int          SEC_WP_LSB     = 24;

  localparam logic [31:0] CTRL_RESET     = 32'h0000_0403;
  localparam logic [31:0] CAPACITY_RESET = 32'h0000_0000;
  localparam logic [31:0] SERIAL_RESET   = 32'h2020_2020;
  localparam logic [15:0] SECURITY_RESET = 16'h0009;
  localparam logic [15:0] MAXCUR_RESET   = 16'h80FA;

  // ----------------------------------------------------------------
  // Page layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_IDENTIFY   = 8'hEC;
  localparam logic [7:0]  LAST_WORD      = 8'hFF;
  localparam logic [7:0]  INTEGRITY_SIG  = 8'hA5;
  localparam logic [15:0] GEN_CONFIG     = 16'h045A;
  localparam logic [15:0] WORD5_VAL      = 16'h0200;
  localparam logic [15:0] SPACE_PAIR     = 16'h2020;
  localparam logic [7:0]  MDMA_SUPPORT   = 8'h07;
  localparam logic [15:0] PIO_ADV        = 16'h0003;
  localparam logic [15:0] CYCLE_TIME     = 16'h0078;
  localparam logic [15:0] CARD_SPEC      = 16'h8000;
  localparam logic [15:0] QUEUE_DEPTH    = 16'h001F;
  localparam logic [15:0] LINK_CAP_NCQ   = 16'h0306;
  localparam logic [15:0] LINK_CAP_PLAIN = 16'h0206;
  localparam logic [15:0] MAJOR_VER      = 16'h01E0;
  localparam logic [15:0] ALL_ONES       = 16'hFFFF;
  localparam logic [15:0] FSET_SUP0      = 16'h742B;
  localparam logic [15:0] FSET_SUP1      = 16'h7401;
  localparam logic [15:0] FSET_COMMON    = 16'h4020;
  localparam logic [15:0] FSET_ENA0      = 16'h7409;
  localparam logic [15:0] FSET_ENA1      = 16'hB401;
  localparam logic [7:0]  UDMA_SUPPORT   = 8'h7F;
  localparam logic [15:0] MASTER_PW_REV  = 16'hFFFE;
  localparam logic [15:0] ONE_WORD       = 16'h0001;
  localparam logic [15:0] FSET_EXT       = 16'h4000;
  localparam logic [15:0] PHY_SLEEP_CAP  = 16'h8001;
  localparam logic [15:0] XPORT_MAJOR    = 16'h101F;

  typedef enum logic [1:0] {
    IDP_IDLE = 2'b00,
    IDP_SEND = 2'b01,
    IDP_DRAIN = 2'b11
  } idp_state_e;

endpackage

// ### dv/idp_monitor.sv
`timescale 1ns/1ps
module idp_monitor
  import idp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_accept,
  input wire logic        cmd_reject,
  input wire logic [15:0] page_data,
  input wire logic        page_valid,
  input wire logic        page_last,
  input wire logic        page_ready
);
  logic [7:0] cnt_r;
  logic [7:0] sum_r;

  // Word position and running byte sum, so page checks need no bench help
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
    end else if (page_valid && page_ready) begin
      cnt_r <= page_last ? 8'h00 : cnt_r + 8'h01;
      sum_r <= page_last ? 8'h00 : sum_r + page_data[15:8] + page_data[7:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // --------
  // Checks
  // --------
  a_ident_accept: assert property (cmd_accept |-> $past(cmd_valid) && $past(cmd_code) == 8'hEC)
    else $error("accept without identify command");
  a_other_reject: assert property (cmd_valid && cmd_code != 8'hEC |=> cmd_reject && !cmd_accept)
    else $error("foreign command not rejected");
  a_first_word: assert property (cmd_accept |=> page_valid && page_data == 16'h045A)
    else $error("first word wrong or late");
  a_fixed_bit6: assert property (page_valid && cnt_r == 8'h00 |-> page_data[6])
    else $error("word zero bit six clear");
  a_data_hold: assert property (page_valid && !page_ready |=> page_valid && $stable(page_data))
    else $error("word dropped while stalled");
  a_last_position: assert property (page_valid |-> page_last == (cnt_r == 8'hFF))
    else $error("last flag off word 255");
  a_word_pio: assert property (page_valid && cnt_r == 8'h40 |-> page_data == 16'h0003)
    else $error("word 64 wrong");
  a_end_sum: assert property (page_valid && page_last |-> page_data[7:0] == 8'hA5 &&
    8'(sum_r + page_data[15:8] + page_data[7:0]) == 8'h00) else $error("integrity word wrong");
  a_stop_after: assert property (page_valid && page_ready && page_last |=> !page_valid)
    else $error("stream runs past word 255");

  c_accept: cover property (cmd_accept);
  c_stall: cover property (page_valid && !page_ready);
  c_done: cover property (page_valid && page_ready && page_last);
endmodule

bind idp_page_builder idp_monitor i_mon (.core_clk, .sys_rst, .cmd_valid, .cmd_code,
  .cmd_accept, .cmd_reject, .page_data, .page_valid, .page_last, .page_ready);

// ### dv/idp_host_model.sv
`timescale 1ns/1ps
module idp_host_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic [15:0] page_data,
  input  wire logic        page_valid,
  input  wire logic        page_last,
  output logic             page_ready,
  output int               pages
);
  logic [15:0] mem [256];
  logic [7:0]  idx_r;
  logic        tick_r;

  // A slow host drops ready every other cycle, so held words get exercised
  assign page_ready = !stall || tick_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_r <= 1'h0;
      idx_r  <= 8'h00;
      pages  <= 0;
    end else begin
      tick_r <= !tick_r;
      if (page_valid && page_ready) begin
        mem[idx_r] <= page_data;
        idx_r      <= page_last ? 8'h00 : idx_r + 8'h01;
        if (page_last) pages <= pages + 1;
      end
    end
  end
endmodule

// ### dv/test_identify_device_page_builder.sv
`timescale 1ns/1ps
module test_identify_device_page_builder;
  import idp_pkg::*;
  logic        core_clk    = 1'h0;
  logic        sys_rst     = 1'h1;
  logic        psel        = 1'h0;
  logic        penable     = 1'h0;
  logic        pwrite      = 1'h0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic        cmd_valid   = 1'h0;
  logic [7:0]  cmd_code    = 8'h00;
  logic        stall       = 1'h0;
  logic [31:0] prdata;
  logic [15:0] page_data;
  logic        pready, pslverr, cmd_accept, cmd_reject, page_valid, page_last, page_ready;
  logic [31:0] rd;
  logic        err, acc, rej;
  int          pages;
  int          failures    = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  idp_page_builder i_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmd_valid, .cmd_code, .cmd_accept, .cmd_reject, .page_data,
    .page_valid, .page_last, .page_ready);
  idp_host_model i_host (.core_clk, .sys_rst, .stall, .page_data, .page_valid, .page_last,
    .page_ready, .pages);

  always #10 core_clk = ~core_clk;

  // One stalled and one unstalled page need about 800 cycles; the ceiling leaves ample slack
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      $display("mismatch at %0t: timeout", $time);
      failures++;
      conclude();
    end
  end

  task conclude();
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task cmd(input logic [7:0] code);
    @(posedge core_clk);
    cmd_valid <= 1'h1;
    cmd_code  <= code;
    @(posedge core_clk);
    cmd_valid <= 1'h0;
    @(posedge core_clk);
    acc = cmd_accept;
    rej = cmd_reject;
  endtask

  task check_page(input logic [15:0] e63, e75, e76, e88, e128, e129, e160,
                  input logic [31:0] cap, ser);
    logic [15:0] w [256];
    logic [7:0]  s;
    w = i_host.mem;
    s = 8'h00;
    foreach (w[i]) s += w[i][15:8] + w[i][7:0];
    chk(w[0], 16'h045A);
    chk(w[0][6], 32'h1);
    chk({w[7], w[8]}, cap);
    chk({w[61], w[60]}, cap);
    for (int i = 10; i < 18; i++) chk(w[i], 16'h2020);
    chk({w[18], w[19]}, ser);
    chk(w[63], e63);
    chk(w[64], 16'h0003);
    for (int i = 65; i < 69; i++) chk(w[i], 16'h0078);
    chk(w[75], e75);
    chk(w[76], e76);
    chk({w[80], w[81]}, 32'h01E0_FFFF);
    chk(w[88], e88);
    chk(w[92], 16'hFFFE);
    chk(w[105], 16'h0001);
    chk({w[119], w[120]}, 32'h4000_4000);
    chk({w[128], w[129]}, {e128, e129});
    chk(w[160], e160);
    chk(w[161], 16'h8001);
    chk({w[169], w[217]}, 32'h0001_0001);
    chk({w[222], w[223]}, 32'h101F_FFFF);
    foreach (w[i]) if (i inside {[70:74], 77, [93:99], 104, [106:107], [112:118],
      [121:127], [162:168], [170:216], [218:221], [224:254]}) chk(w[i], 16'h0000);
    chk({w[255][7:0], s}, 16'hA500);
  endtask

  task t_regs();
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0403);
    apb(1'h0, ADDR_SECURITY, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'h0, ADDR_MAXCUR, 32'h0);
    chk(rd, 32'h0000_80FA);
    apb(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
  endtask

  task t_bad_cmds();
    logic [7:0] codes [3];
    codes = '{8'h20, 8'hEB, 8'hED};
    foreach (codes[i]) begin
      cmd(codes[i]);
      chk({acc, rej}, 32'h1);
    end
  endtask

  task t_default_page();
    stall <= 1'h1;
    cmd(8'hEC);
    chk({acc, rej}, 32'h2);
    cmd(8'hEC);
    chk({acc, rej}, 32'h1);
    apb(1'h1, ADDR_MAXCUR, 32'h0000_1234);
    while (pages != 1) @(posedge core_clk);
    check_page(16'h0407, 16'h001F, 16'h0306, 16'h007F, 16'h0009, 16'h0000, 16'h80FA,
               32'h0, 32'h2020_2020);
    apb(1'h0, ADDR_MAXCUR, 32'h0);
    chk(rd, 32'h0000_80FA);
  endtask

  task t_custom_page();
    stall <= 1'h0;
    apb(1'h1, ADDR_CTRL, 32'h0040_0100);
    apb(1'h1, ADDR_CAPACITY, 32'h0001_2345);
    apb(1'h1, ADDR_SERIAL, 32'h4142_4344);
    apb(1'h1, ADDR_SECURITY, 32'h8000_0019);
    apb(1'h1, ADDR_MAXCUR, 32'h0000_80C8);
    cmd(8'hEC);
    while (pages != 2) @(posedge core_clk);
    check_page(16'h0000, 16'h0000, 16'h0206, 16'h407F, 16'h0019, 16'h8000, 16'h80C8,
               32'h0001_2345, 32'h4142_4344);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0002_0000);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_regs();
    t_bad_cmds();
    t_default_page();
    t_custom_page();
    conclude();
  end
endmodule
